// *** pqs_pkg.sv ***
// Package with register layout and codes for the quick-poll status block
package pqs_pkg;
    localparam int          PQS_REG_W        = 16;
    localparam logic [4:0]  PQS_REG_ADDR     = 5'h11;
    localparam int          PQS_MON_HI       = 13;
    localparam int          PQS_MON_LO       = 11;
    localparam int          PQS_SIG_LOST_BIT = 10;
    localparam int          PQS_LOCK_ERR_BIT = 9;
    localparam int          PQS_FALSE_CR_BIT = 8;
    localparam int          PQS_INV_SYM_BIT  = 7;
    localparam int          PQS_HALT_BIT     = 6;
    localparam int          PQS_PREM_END_BIT = 5;
    localparam int          PQS_DONE_BIT     = 4;
    localparam int          PQS_NUM_EVT      = 6;
    localparam logic [2:0]  PQS_MON_RESET    = 3'h0;
    localparam logic [5:0]  PQS_EVT_RESET    = 6'h00;
    // Progress codes of the negotiation state machine
    localparam logic [2:0]  PQS_AN_IDLE      = 3'h0;
    localparam logic [2:0]  PQS_AN_PAR_DET   = 3'h1;
    localparam logic [2:0]  PQS_AN_PAR_FAIL  = 3'h2;
    localparam logic [2:0]  PQS_AN_ABIL_OK   = 3'h3;
    localparam logic [2:0]  PQS_AN_ACK_FAIL  = 3'h4;
    localparam logic [2:0]  PQS_AN_ACK_OK    = 3'h5;
    localparam logic [2:0]  PQS_AN_CONS_FAIL = 3'h6;
    localparam logic [2:0]  PQS_AN_CONS_OK   = 3'h7;
endpackage

// *** pqs_latch_bit.sv ***
// One latch-high status flag with read-clear where a new event wins
module pqs_latch_bit (
    input  wire logic clk_i,
    input  wire logic resetn_i,
    input  wire logic event_i,
    input  wire logic clear_i,
    output logic      flag_o
);
    logic flag_q;
    logic flag_d;

    // Set beats clear so an event in the read cycle survives
    assign flag_d = event_i | (flag_q & ~clear_i);

    // Flag storage
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            flag_q <= 1'b0;
        end else begin
            flag_q <= flag_d;
        end
    end

    assign flag_o = flag_q;
endmodule

// *** pqs_status.sv ***
// Quick-poll status: negotiation progress monitor and receive latch-high flags
// What this block does
// (R1) Report negotiation progress in bits 13:11, done 4
// (R2) Progress clears on reset, disable, restart
// (R3) Between reads, progress only rises while negotiation enabled
// (R4) Read returns history, then loads current state
// (R5) Progress codes idle 000 through matched 111
// (R6) Signal-lost flag bit 10 latches high
// (R7) PLL lock-error flag bit 9 latches high
// (R8) False-carrier flag bit 8 on bad J/K
// (R9) In-packet symbol error raises error out and bit 7
// (R10) In-packet halt symbol signalled, sets bit 6
// (R11) Two idles in packet set bit 5
// (R12) Event flags latch high until read
// (R13) Flags meaningless in 10 Mb/s mode
// (R14) Done flag one when finished, zero if disabled
// (R15) Read clears only what it returned
module pqs_status
    import pqs_pkg::*;
(
    input  wire logic                 clk_i,
    input  wire logic                 resetn_i,
    input  wire logic                 an_enable_i,
    input  wire logic                 an_restart_i,
    input  wire logic [2:0]           an_state_i,
    input  wire logic                 an_done_i,
    input  wire logic                 rx_sig_lost_i,
    input  wire logic                 rx_lock_err_i,
    input  wire logic                 rx_false_carrier_i,
    input  wire logic                 rx_in_packet_i,
    input  wire logic                 rx_sym_err_i,
    input  wire logic                 rx_halt_sym_i,
    input  wire logic                 rx_idle_sym_i,
    input  wire logic                 rx_sym_valid_i,
    input  wire logic                 reg_rd_i,
    output logic [PQS_REG_W-1:0]      reg_rdata_o,
    output logic                      rx_err_o,
    output logic                      rx_halt_o
);
    logic [2:0]             mon_q;
    logic [2:0]             mon_d;
    logic                   done_q;
    logic                   prev_idle_q;
    logic                   rx_err_q;
    logic                   rx_halt_q;
    logic [PQS_REG_W-1:0]   rdata_q;
    logic [PQS_NUM_EVT-1:0] evt_raw;
    logic [PQS_NUM_EVT-1:0] evt_flag;
    wire                    mon_clear;
    wire                    mon_rises;
    wire                    prem_end;
    wire  [PQS_REG_W-1:0]   status_word;

    // Clear conditions and highest-state comparison
    assign mon_clear = ~an_enable_i | an_restart_i;            // [R2]
    assign mon_rises = an_state_i > mon_q;                     // [R3]
    assign prem_end  = rx_in_packet_i & rx_sym_valid_i & rx_idle_sym_i
                       & prev_idle_q;                          // [R11]

    // Next progress value; a read reloads the live state after the history goes out
    always_comb begin
        mon_d = mon_q;
        if (mon_clear) begin
            mon_d = PQS_MON_RESET;                             // [R2]
        end else if (reg_rd_i) begin
            mon_d = an_state_i;                                // [R4]
        end else if (mon_rises) begin
            mon_d = an_state_i;                                // [R3] [R5]
        end
    end

    // Progress and done storage
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            mon_q  <= PQS_MON_RESET;                           // [R2]
            done_q <= 1'b0;
        end else begin
            mon_q  <= mon_d;                                   // [R1]
            done_q <= an_enable_i & ~an_restart_i & an_done_i; // [R14]
        end
    end

    // Remembers the last in-packet symbol being idle, for the two-idle check
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            prev_idle_q <= 1'b0;
        end else if (!rx_in_packet_i) begin
            prev_idle_q <= 1'b0;
        end else if (rx_sym_valid_i) begin
            prev_idle_q <= rx_idle_sym_i;
        end
    end

    // Indications toward the MAC, registered
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rx_err_q  <= 1'b0;
            rx_halt_q <= 1'b0;
        end else begin
            rx_err_q  <= rx_in_packet_i & rx_sym_err_i;        // [R9]
            rx_halt_q <= rx_in_packet_i & rx_halt_sym_i;       // [R10]
        end
    end

    // Event sources; no 10 Mb/s gating since the flags are undefined there [R13]
    assign evt_raw[0] = prem_end;                              // [R11]
    assign evt_raw[1] = rx_in_packet_i & rx_halt_sym_i;        // [R10]
    assign evt_raw[2] = rx_in_packet_i & rx_sym_err_i;         // [R9]
    assign evt_raw[3] = rx_false_carrier_i;                    // [R8]
    assign evt_raw[4] = rx_lock_err_i;                         // [R7]
    assign evt_raw[5] = rx_sig_lost_i;                         // [R6]

    // One latch-high cell per flag, cleared by a read
    genvar gi;
    generate
        for (gi = 0; gi < PQS_NUM_EVT; gi++) begin : g_evt
            pqs_latch_bit u_bit (
                .clk_i   (clk_i),
                .resetn_i(resetn_i),
                .event_i (evt_raw[gi]),
                .clear_i (reg_rd_i),                           // [R12] [R15]
                .flag_o  (evt_flag[gi])
            );
        end
    endgenerate

    // Register image; unmodelled bits read as zero
    assign status_word = {2'h0, mon_q, evt_flag, done_q, 4'h0}; // [R1]

    // Read data captured on the read strobe, held until the next read
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rdata_q <= '0;
        end else if (reg_rd_i) begin
            rdata_q <= status_word;                            // [R4] [R15]
        end
    end

    assign reg_rdata_o = rdata_q;
    assign rx_err_o    = rx_err_q;
    assign rx_halt_o   = rx_halt_q;

    // Monitor must be zero the cycle after disable or restart
    mon_clear_a: assert property (@(posedge clk_i) disable iff (!resetn_i) // [R2]
        mon_clear |=> mon_q == PQS_MON_RESET)
        else $error("progress not cleared");

    // Monitor never decreases without clear or read
    mon_mono_a: assert property (@(posedge clk_i) disable iff (!resetn_i) // [R3]
        !$past(mon_clear) && !$past(reg_rd_i) |-> mon_q >= $past(mon_q))
        else $error("progress dropped");

    // Monitor tracks a higher state one cycle later
    mon_rise_a: assert property (@(posedge clk_i) disable iff (!resetn_i) // [R3]
        !mon_clear && !reg_rd_i && mon_rises |=> mon_q == $past(an_state_i))
        else $error("progress missed rise");

    sequence rd_seq;
        reg_rd_i && !mon_clear;
    endsequence
    // Read returns history then loads live state
    mon_read_a: assert property (@(posedge clk_i) disable iff (!resetn_i) // [R4]
        rd_seq |=> reg_rdata_o[PQS_MON_HI:PQS_MON_LO] == $past(mon_q)
                   && mon_q == $past(an_state_i))
        else $error("read did not reload progress");

    // Lost signal latched and held until a read
    sig_lost_a: assert property (@(posedge clk_i) disable iff (!resetn_i) // [R6]
        rx_sig_lost_i ##1 !reg_rd_i |=> evt_flag[5])
        else $error("signal lost not held");

    // Lock error shows on next read
    lock_err_a: assert property (@(posedge clk_i) disable iff (!resetn_i) // [R7]
        rx_lock_err_i ##1 reg_rd_i |=> reg_rdata_o[PQS_LOCK_ERR_BIT])
        else $error("lock error not reported");

    // Event in read cycle survives the clear
    evt_keep_a: assert property (@(posedge clk_i) disable iff (!resetn_i) // [R15]
        reg_rd_i && rx_false_carrier_i |=> evt_flag[3])
        else $error("event lost on read");

    // Flag cleared by a read with no event
    evt_clr_a: assert property (@(posedge clk_i) disable iff (!resetn_i) // [R12]
        reg_rd_i && !rx_sig_lost_i |=> !evt_flag[5])
        else $error("flag not cleared by read");

    // Symbol error drives both error output and flag
    sym_err_a: assert property (@(posedge clk_i) disable iff (!resetn_i) // [R9]
        rx_in_packet_i && rx_sym_err_i |=> rx_err_o && evt_flag[2])
        else $error("symbol error not reported");

    // Halt symbol signalled and flagged
    halt_sym_a: assert property (@(posedge clk_i) disable iff (!resetn_i) // [R10]
        rx_in_packet_i && rx_halt_sym_i |=> rx_halt_o && evt_flag[1])
        else $error("halt not reported");

    sequence idle_sym_seq;
        rx_in_packet_i && rx_sym_valid_i && rx_idle_sym_i;
    endsequence
    // Two idles back to back set premature end
    prem_end_a: assert property (@(posedge clk_i) disable iff (!resetn_i) // [R11]
        idle_sym_seq ##1 idle_sym_seq |=> evt_flag[0])
        else $error("premature end missed");

    // Done reads zero while disabled
    done_dis_a: assert property (@(posedge clk_i) disable iff (!resetn_i) // [R14]
        !an_enable_i |=> !done_q)
        else $error("done set while disabled");

    // Done follows a completed, enabled negotiation
    done_set_a: assert property (@(posedge clk_i) disable iff (!resetn_i) // [R14]
        an_enable_i && !an_restart_i && an_done_i |=> done_q)
        else $error("done not set");

    // Error output quiet without an in-packet symbol error
    err_quiet_a: assert property (@(posedge clk_i) disable iff (!resetn_i) // [R9]
        !(rx_in_packet_i && rx_sym_err_i) |=> !rx_err_o)
        else $error("spurious receive error");

    // Halt output quiet without an in-packet halt symbol
    halt_quiet_a: assert property (@(posedge clk_i) disable iff (!resetn_i) // [R10]
        !(rx_in_packet_i && rx_halt_sym_i) |=> !rx_halt_o)
        else $error("spurious halt indication");

    // Read data stands until the next read, so a slow poller sees one word
    rdata_hold_a: assert property (@(posedge clk_i) disable iff (!resetn_i) // [R4]
        !reg_rd_i |=> $stable(reg_rdata_o))
        else $error("read data changed without a read");
endmodule

// *** pqs_sta_model.sv ***
// Station management model: issues status reads and captures each answer
module pqs_sta_model
    import pqs_pkg::*;
(
    input  wire logic                 clk_i,
    input  wire logic                 resetn_i,
    input  wire logic                 go_i,
    input  wire logic [PQS_REG_W-1:0] rdata_i,
    output logic                      reg_rd_o,
    output logic [PQS_REG_W-1:0]      data_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic seen_q;
    // One-cycle strobe per request; answer is taken one cycle after the read edge
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            reg_rd_o <= 1'h0;
            seen_q   <= 1'h0;
            data_o   <= '0;
        end else begin
            reg_rd_o <= go_i;
            seen_q   <= reg_rd_o;
            if (seen_q) begin
                data_o <= rdata_i;
            end
        end
    end
endmodule

// *** pqs_status_tb.sv ***
// Testbench for the quick-poll status block
module pqs_status_tb
    import pqs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct {logic [7:0] rx; logic err; logic halt; logic [15:0] rd;} pqs_row_t;
    logic clk_i, resetn, go, en, rst_an, done, err, halt;
    logic [2:0] st;
    logic [7:0] rx;
    logic rd;
    logic [15:0] rdata, data, d;
    int fail_count, num_checks;
    // rx: sig lost, lock err, false carrier, in packet, sym err, halt, idle, valid
    pqs_row_t rows [10] = '{
        '{8'h80, 1'h0, 1'h0, 16'h0400}, '{8'h40, 1'h0, 1'h0, 16'h0200},
        '{8'h20, 1'h0, 1'h0, 16'h0100}, '{8'h18, 1'h1, 1'h0, 16'h0080},
        '{8'h14, 1'h0, 1'h1, 16'h0040}, '{8'h13, 1'h0, 1'h0, 16'h0020},
        '{8'h08, 1'h0, 1'h0, 16'h0000}, '{8'h04, 1'h0, 1'h0, 16'h0000},
        '{8'h12, 1'h0, 1'h0, 16'h0000}, '{8'h03, 1'h0, 1'h0, 16'h0000}};
    pqs_status pqs_status_i (.clk_i(clk_i), .resetn_i(resetn), .an_enable_i(en),
        .an_restart_i(rst_an), .an_state_i(st), .an_done_i(done),
        .rx_sig_lost_i(rx[7]), .rx_lock_err_i(rx[6]), .rx_false_carrier_i(rx[5]),
        .rx_in_packet_i(rx[4]), .rx_sym_err_i(rx[3]), .rx_halt_sym_i(rx[2]),
        .rx_idle_sym_i(rx[1]), .rx_sym_valid_i(rx[0]), .reg_rd_i(rd),
        .reg_rdata_o(rdata), .rx_err_o(err), .rx_halt_o(halt));
    pqs_sta_model pqs_sta_model_i (.clk_i(clk_i), .resetn_i(resetn), .go_i(go),
        .rdata_i(rdata), .reg_rd_o(rd), .data_o(data));
    // Free-running 20 MHz clock
    initial begin
        clk_i = 1'h0;
        forever #25 clk_i = ~clk_i;
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
            fail_count++;
        end
    endtask
    // Event in ev is sampled at the same edge as the read itself
    task automatic do_read(input logic [7:0] ev, output logic [15:0] q);
        @(posedge clk_i) go <= 1'h1;
        @(posedge clk_i) go <= 1'h0;
        rx <= ev;
        @(posedge clk_i) rx <= 8'h00;
        @(posedge clk_i);
        #1 q = data;
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Watchdog: the whole sequence is far shorter than this
    initial begin
        repeat (5000) @(posedge clk_i);
        fail_count++;
        give_verdict();
    end
    initial begin
        {resetn, go, en, rst_an, done, st, rx} = '0;
        repeat (8) @(posedge clk_i);
        resetn <= 1'h1;
        en <= 1'h1;
        // Each row: event for three sampled cycles, then read twice
        foreach (rows[i]) begin
            @(posedge clk_i) rx <= rows[i].rx;
            @(posedge clk_i);
            #1 chk({14'h0, err, halt}, {14'h0, rows[i].err, rows[i].halt});
            do_read(8'h00, d);
            chk(d, rows[i].rd);
            do_read(8'h00, d);
            chk(d, 16'h0000);
        end
        $display("test event rows done");
        do_read(8'h60, d);
        chk(d, 16'h0000);
        do_read(8'h00, d);
        chk(d, 16'h0300);
        $display("test read race done");
        // Progress codes 1 through 7, each after a restart
        for (int c = 1; c < 8; c++) begin
            @(posedge clk_i) rst_an <= 1'h1;
            st <= 3'h0;
            @(posedge clk_i) rst_an <= 1'h0;
            st <= c[2:0];
            do_read(8'h00, d);
            chk(d, {2'h0, c[2:0], 11'h0});
        end
        @(posedge clk_i) rst_an <= 1'h1;
        @(posedge clk_i) rst_an <= 1'h0;
        st <= 3'h3;
        @(posedge clk_i) st <= 3'h1;
        do_read(8'h00, d);
        chk(d, 16'h1800);
        do_read(8'h00, d);
        chk(d, 16'h0800);
        @(posedge clk_i) en <= 1'h0;
        st <= 3'h7;
        done <= 1'h1;
        do_read(8'h00, d);
        chk(d, 16'h0000);
        @(posedge clk_i) en <= 1'h1;
        st <= 3'h0;
        do_read(8'h00, d);
        chk(d, 16'h0010);
        $display("test progress done");
        // Reset in mid-run drops a pending flag
        @(posedge clk_i) rx <= 8'h40;
        @(posedge clk_i) rx <= 8'h00;
        resetn <= 1'h0;
        repeat (2) @(posedge clk_i);
        #1 chk(rdata, 16'h0000);
        @(posedge clk_i) resetn <= 1'h1;
        do_read(8'h00, d);
        chk(d, 16'h0010);
        $display("test reset done");
        give_verdict();
    end
endmodule
